// File: logic/tes_pkg.sv
// Purpose: Shared constants and types of the table extremum search block.
// Assumes: 16-bit table words, 32-bit APB data, 20-bit word memory address.
// Notes:   Register offsets are byte addresses on the APB bus.
package tes_pkg;
   // ==========================================================
   // Widths
   localparam int WORD_W = 16;
   localparam int ADDR_W = 20;
   localparam int VAL_W  = 64;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_LEN      = 8'h00;
   localparam logic [7:0] OFS_OPT      = 8'h04;
   localparam logic [7:0] OFS_OP       = 8'h08;
   localparam logic [7:0] OFS_SRC      = 8'h0C;
   localparam logic [7:0] OFS_DST      = 8'h10;
   localparam logic [7:0] OFS_START    = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   localparam logic [7:0] OFS_INDEX    = 8'h1C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h24;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;
   localparam logic [7:0] OFS_RES_LO   = 8'h2C;
   localparam logic [7:0] OFS_RES_HI   = 8'h30;

   // ==========================================================
   // Field positions
   localparam int OPT_ADDR_OUT_BIT = 14;
   localparam int OPT_SIGNED_BIT   = 15;
   localparam int ST_BUSY_BIT      = 0;
   localparam int ST_ERR_BIT       = 1;
   localparam int ST_EQ_BIT        = 2;
   localparam int ST_NEG_BIT       = 3;
   localparam int IRQ_DONE_BIT     = 0;
   localparam int IRQ_ERR_BIT      = 1;
   localparam int IRQ_N            = 2;

   // ==========================================================
   // Reset values
   localparam logic [WORD_W-1:0] LEN_RST   = 16'h0000;
   localparam logic [WORD_W-1:0] OPT_RST   = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
   localparam logic [VAL_W-1:0]  VAL_RST   = 64'h0000_0000_0000_0000;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      TES_OP_MAX_F32 = 2'h0,
      TES_OP_MAX_F64 = 2'h1,
      TES_OP_MIN_DW  = 2'h2,
      TES_OP_MIN_F32 = 2'h3
   } tes_op_t;

   typedef enum logic [1:0] {
      TES_FMT_F32,
      TES_FMT_F64,
      TES_FMT_U32,
      TES_FMT_S32
   } tes_fmt_t;

   typedef enum logic [2:0] {
      TES_IDLE,
      TES_READ,
      TES_EVAL,
      TES_WRITE,
      TES_FINISH,
      TES_DONE
   } tes_state_t;
endpackage : tes_pkg

// File: logic/tes_cmp_if.sv
// Purpose: Carries one comparison between the scan engine and the comparator.
// Assumes: Purely combinational exchange.
// Notes:   cand is the new entry, best the extreme found so far.
`timescale 1ns/1ps
interface tes_cmp_if;
   import tes_pkg::*;
   logic [VAL_W-1:0] cand;
   logic [VAL_W-1:0] best;
   tes_fmt_t         fmt;
   logic             want_max;
   logic             better;
   logic             nonnum;
   logic             is_zero;
   logic             is_neg;
   modport engine (output cand, best, fmt, want_max, input better, nonnum, is_zero, is_neg);
   modport unit   (input cand, best, fmt, want_max, output better, nonnum, is_zero, is_neg);
endinterface : tes_cmp_if

// File: logic/tes_compare.sv
// Purpose: Orders two table entries of a given format.
// Assumes: Non-numeric entries are caught before their order matters.
// Notes:   Floats map to an unsigned key; both zeros map to one key.
`timescale 1ns/1ps
module tes_compare (
   tes_cmp_if.unit cmp   // Comparison request and answer.
);
   import tes_pkg::*;

   function automatic logic [VAL_W-1:0] key_of(input logic [VAL_W-1:0] x, input tes_fmt_t f);
      logic [VAL_W-1:0] k;
      k = '0;
      case (f)
         TES_FMT_F64: begin
            if (x[62:0] == 63'h0) k = 64'h8000_0000_0000_0000;
            else if (x[63]) k = ~x;
            else k = {1'b1, x[62:0]};
         end
         TES_FMT_F32: begin
            if (x[30:0] == 31'h0) k = 64'h0000_0000_8000_0000;
            else if (x[31]) k = {32'h0000_0000, ~x[31:0]};
            else k = {32'h0000_0000, 1'b1, x[30:0]};
         end
         TES_FMT_S32: k = {32'h0000_0000, ~x[31], x[30:0]};
         default:     k = {32'h0000_0000, x[31:0]};
      endcase
      return k;
   endfunction : key_of

   logic [VAL_W-1:0] cand_key;
   logic [VAL_W-1:0] best_key;

   always_comb begin
      cand_key = key_of(cmp.cand, cmp.fmt);
      best_key = key_of(cmp.best, cmp.fmt);
      // Strict order only, so a tie keeps the earlier entry.
      cmp.better = cmp.want_max ? (cand_key > best_key) : (cand_key < best_key);
      // An all-ones exponent (NaN or infinity) is not a usable number.
      case (cmp.fmt)
         TES_FMT_F64: cmp.nonnum = (cmp.cand[62:52] == 11'h7FF);
         TES_FMT_F32: cmp.nonnum = (cmp.cand[30:23] == 8'hFF);
         default:     cmp.nonnum = 1'b0;
      endcase
      case (cmp.fmt)
         TES_FMT_F64: cmp.is_zero = (cmp.best[62:0] == 63'h0);
         TES_FMT_F32: cmp.is_zero = (cmp.best[30:0] == 31'h0);
         default:     cmp.is_zero = (cmp.best[31:0] == 32'h0000_0000);
      endcase
      case (cmp.fmt)
         TES_FMT_F64: cmp.is_neg = cmp.best[63] && !cmp.is_zero;
         TES_FMT_F32: cmp.is_neg = cmp.best[31] && !cmp.is_zero;
         default:     cmp.is_neg = cmp.best[31];
      endcase
   end
endmodule : tes_compare

// File: logic/tes_search.sv
// Purpose: Scans a word-memory table for its largest or smallest entry.
// Assumes: APB register access; a request/acknowledge word memory port.
// Notes:   One operation at a time; starts while busy are ignored.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps

// Function
// - Max single float: scan 2W words as W floats, write largest to D, D+1.
// - Max double float: scan 4W words as W doubles, write largest to D..D+3.
// - Min double word: scan 2W words as W 32-bit values, write smallest.
// - Option bit 14 set loads index register with lower-word address of extreme.
// - On ties the earliest matching entry's address is reported.
// - Option bit 14 clear leaves the index register unchanged.
// - Min double word with option bit 15 set compares signed values.
// - Length from bits 0-15 of first word; zero length sets error, else cleared unless an entry is non-numeric.
// - Float maximum operations flag error on any non-numeric entry.
// - Maximum operations set equals flag exactly when the maximum is zero.
// - Min double word sets equals flag exactly when the minimum is zero.
// - Float maximum operations set negative flag when the maximum is negative.
// - Min double word negative flag equals bit 15 of upper destination word.
// - Min single float: scan 2W words as W floats, write smallest to D, D+1.
module tes_search
   import tes_pkg::*;
(
   input  wire logic                  core_clk_in,    // System clock, 100 MHz.
   input  wire logic                  nrst_in,        // Asynchronous reset, active low.
   input  wire logic                  psel_in,        // APB select.
   input  wire logic                  penable_in,     // APB enable.
   input  wire logic                  pwrite_in,      // APB write direction.
   input  wire logic [7:0]            paddr_in,       // APB byte address.
   input  wire logic [31:0]           pwdata_in,      // APB write data.
   output logic      [31:0]           prdata_out,     // APB read data.
   output logic                       pready_out,     // APB ready.
   output logic                       pslverr_out,    // APB error, unmapped address.
   output logic                       mem_req_out,    // Word memory request.
   output logic                       mem_we_out,     // Word memory write.
   output logic      [tes_pkg::ADDR_W-1:0] mem_addr_out, // Word memory address.
   output logic      [tes_pkg::WORD_W-1:0] mem_wdata_out, // Word memory write data.
   input  wire logic [tes_pkg::WORD_W-1:0] mem_rdata_in,  // Word memory read data.
   input  wire logic                  mem_ack_in,     // Word memory acknowledge.
   output logic                       irq_out         // Level interrupt.
);
   import tes_pkg::*;

   // ==========================================================
   // Declarations
   tes_state_t         state_ff,      nxt_state;
   tes_op_t            op_ff,         nxt_op;
   logic [WORD_W-1:0]  len_ff,        nxt_len;
   logic [WORD_W-1:0]  opt_ff,        nxt_opt;
   tes_op_t            op_cfg_ff,     nxt_op_cfg;
   logic [ADDR_W-1:0]  src_ff,        nxt_src;
   logic [ADDR_W-1:0]  dst_ff,        nxt_dst;
   logic [WORD_W-1:0]  cnt_ff,        nxt_cnt;
   logic [1:0]         widx_ff,       nxt_widx;
   logic [ADDR_W-1:0]  addr_ff,       nxt_addr;
   logic [ADDR_W-1:0]  ent_addr_ff,   nxt_ent_addr;
   logic [ADDR_W-1:0]  best_addr_ff,  nxt_best_addr;
   logic [VAL_W-1:0]   cand_ff,       nxt_cand;
   logic [VAL_W-1:0]   best_ff,       nxt_best;
   logic               have_ff,       nxt_have;
   logic               err_ff,        nxt_err;
   logic               eq_ff,         nxt_eq;
   logic               neg_ff,        nxt_neg;
   logic [ADDR_W-1:0]  index_ff,      nxt_index;
   logic [VAL_W-1:0]   res_ff,        nxt_res;
   logic [IRQ_N-1:0]   irq_stat_ff,   nxt_irq_stat;
   logic [IRQ_N-1:0]   irq_en_ff,     nxt_irq_en;

   logic               wr_acc;
   logic               rd_acc;
   logic               start_req;
   logic [IRQ_N-1:0]   irq_evt;
   logic [IRQ_N-1:0]   irq_clr;
   logic [1:0]         last_widx;
   tes_fmt_t           fmt;

   tes_cmp_if cmp ();

   tes_compare u_compare (
      .cmp (cmp)
   );

   // ==========================================================
   // Format decode
   always_comb begin
      case (op_ff)
         TES_OP_MAX_F32: fmt = TES_FMT_F32;
         TES_OP_MAX_F64: fmt = TES_FMT_F64;
         TES_OP_MIN_F32: fmt = TES_FMT_F32;
         default: fmt = opt_ff[OPT_SIGNED_BIT] ? TES_FMT_S32 : TES_FMT_U32;
      endcase
      // Double floats span four words, the other formats two.
      last_widx = (op_ff == TES_OP_MAX_F64) ? 2'd3 : 2'd1;
   end

   assign cmp.cand     = cand_ff;
   assign cmp.best     = best_ff;
   assign cmp.fmt      = fmt;
   assign cmp.want_max = (op_ff == TES_OP_MAX_F32) || (op_ff == TES_OP_MAX_F64);

   // ==========================================================
   // Memory port
   always_comb begin
      mem_req_out   = (state_ff == TES_READ) || (state_ff == TES_WRITE);
      mem_we_out    = (state_ff == TES_WRITE);
      mem_addr_out  = (state_ff == TES_WRITE) ? dst_ff + ADDR_W'(widx_ff) : addr_ff;
      mem_wdata_out = best_ff[16*widx_ff +: WORD_W];
   end

   // ==========================================================
   // Scan engine
   always_comb begin
      nxt_state     = state_ff;
      nxt_op        = op_ff;
      nxt_cnt       = cnt_ff;
      nxt_widx      = widx_ff;
      nxt_addr      = addr_ff;
      nxt_ent_addr  = ent_addr_ff;
      nxt_best_addr = best_addr_ff;
      nxt_cand      = cand_ff;
      nxt_best      = best_ff;
      nxt_have      = have_ff;
      nxt_err       = err_ff;
      nxt_eq        = eq_ff;
      nxt_neg       = neg_ff;
      nxt_index     = index_ff;
      nxt_res       = res_ff;
      irq_evt       = '0;
      case (state_ff)
         TES_IDLE: begin
            if (start_req) begin
               nxt_op = op_cfg_ff;
               if (len_ff == LEN_RST) begin
                  // Zero length: flag and stop before touching memory.
                  nxt_err   = 1'b1;
                  nxt_state = TES_DONE;
               end else begin
                  nxt_cnt      = len_ff;
                  nxt_addr     = src_ff;
                  nxt_ent_addr = src_ff;
                  nxt_widx     = 2'd0;
                  nxt_have     = 1'b0;
                  nxt_state    = TES_READ;
               end
            end
         end
         TES_READ: begin
            if (mem_ack_in) begin
               nxt_cand[16*widx_ff +: WORD_W] = mem_rdata_in;
               nxt_addr = addr_ff + ADDR_W'(1);
               if (widx_ff == last_widx) begin
                  nxt_state = TES_EVAL;
               end else begin
                  nxt_widx = widx_ff + 2'd1;
               end
            end
         end
         TES_EVAL: begin
            if (cmp.nonnum) begin
               // Abort on a non-numeric entry; results stay as they were.
               nxt_err   = 1'b1;
               nxt_state = TES_DONE;
            end else begin
               if (!have_ff || cmp.better) begin
                  nxt_best      = cand_ff;
                  nxt_best_addr = ent_addr_ff;
                  nxt_have      = 1'b1;
               end
               nxt_cand     = VAL_RST;
               nxt_cnt      = cnt_ff - WORD_W'(1);
               nxt_widx     = 2'd0;
               nxt_ent_addr = addr_ff;
               nxt_state    = (cnt_ff == WORD_W'(1)) ? TES_WRITE : TES_READ;
            end
         end
         TES_WRITE: begin
            if (mem_ack_in) begin
               // Result words go out lowest first to D, D+1 and onward.
               if (widx_ff == last_widx) begin
                  nxt_state = TES_FINISH;
               end else begin
                  nxt_widx = widx_ff + 2'd1;
               end
            end
         end
         TES_FINISH: begin
            nxt_err = 1'b0;
            nxt_eq  = cmp.is_zero;
            nxt_neg = cmp.is_neg;
            nxt_res = best_ff;
            if (opt_ff[OPT_ADDR_OUT_BIT]) begin
               nxt_index = best_addr_ff;
            end
            nxt_state = TES_DONE;
         end
         TES_DONE: begin
            irq_evt[IRQ_DONE_BIT] = 1'b1;
            irq_evt[IRQ_ERR_BIT]  = err_ff;
            nxt_state = TES_IDLE;
         end
         default: nxt_state = TES_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_ff     <= TES_IDLE;
         op_ff        <= TES_OP_MAX_F32;
         cnt_ff       <= LEN_RST;
         widx_ff      <= 2'd0;
         addr_ff      <= ADDR_RST;
         ent_addr_ff  <= ADDR_RST;
         best_addr_ff <= ADDR_RST;
         cand_ff      <= VAL_RST;
         best_ff      <= VAL_RST;
         have_ff      <= 1'b0;
         err_ff       <= 1'b0;
         eq_ff        <= 1'b0;
         neg_ff       <= 1'b0;
         index_ff     <= ADDR_RST;
         res_ff       <= VAL_RST;
      end else begin
         state_ff     <= nxt_state;
         op_ff        <= nxt_op;
         cnt_ff       <= nxt_cnt;
         widx_ff      <= nxt_widx;
         addr_ff      <= nxt_addr;
         ent_addr_ff  <= nxt_ent_addr;
         best_addr_ff <= nxt_best_addr;
         cand_ff      <= nxt_cand;
         best_ff      <= nxt_best;
         have_ff      <= nxt_have;
         err_ff       <= nxt_err;
         eq_ff        <= nxt_eq;
         neg_ff       <= nxt_neg;
         index_ff     <= nxt_index;
         res_ff       <= nxt_res;
      end
   end

   // ==========================================================
   // APB register file
   assign pready_out = 1'b1;
   assign wr_acc     = psel_in && penable_in && pwrite_in;
   assign rd_acc     = psel_in && penable_in && !pwrite_in;

   always_comb begin
      start_req    = 1'b0;
      irq_clr      = '0;
      nxt_len      = len_ff;
      nxt_opt      = opt_ff;
      nxt_op_cfg   = op_cfg_ff;
      nxt_src      = src_ff;
      nxt_dst      = dst_ff;
      nxt_irq_en   = irq_en_ff;
      // Configuration is frozen while a scan runs so the engine sees stable operands.
      if (wr_acc && state_ff == TES_IDLE) begin
         case (paddr_in)
            OFS_LEN:   nxt_len    = pwdata_in[WORD_W-1:0];
            OFS_OPT:   nxt_opt    = pwdata_in[WORD_W-1:0];
            OFS_OP:    nxt_op_cfg = tes_op_t'(pwdata_in[1:0]);
            OFS_SRC:   nxt_src    = pwdata_in[ADDR_W-1:0];
            OFS_DST:   nxt_dst    = pwdata_in[ADDR_W-1:0];
            OFS_START: start_req  = pwdata_in[0];
            default:   start_req  = 1'b0;
         endcase
      end
      if (wr_acc && paddr_in == OFS_IRQ_EN) begin
         nxt_irq_en = pwdata_in[IRQ_N-1:0];
      end
      if (wr_acc && paddr_in == OFS_IRQ_CLR) begin
         irq_clr = pwdata_in[IRQ_N-1:0];
      end
      // A new event wins over a clear in the same cycle.
      nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_evt;

      prdata_out  = 32'h0000_0000;
      pslverr_out = 1'b0;
      case (paddr_in)
         OFS_LEN:      prdata_out = {16'h0000, len_ff};
         OFS_OPT:      prdata_out = {16'h0000, opt_ff};
         OFS_OP:       prdata_out = {30'h0, op_cfg_ff};
         OFS_SRC:      prdata_out = {12'h000, src_ff};
         OFS_DST:      prdata_out = {12'h000, dst_ff};
         OFS_START:    prdata_out = 32'h0000_0000;
         OFS_STATUS:   prdata_out = {28'h000_0000, neg_ff, eq_ff, err_ff,
                                     state_ff != TES_IDLE};
         OFS_INDEX:    prdata_out = {12'h000, index_ff};
         OFS_IRQ_STAT: prdata_out = {30'h0, irq_stat_ff};
         OFS_IRQ_EN:   prdata_out = {30'h0, irq_en_ff};
         OFS_IRQ_CLR:  prdata_out = 32'h0000_0000;
         OFS_RES_LO:   prdata_out = res_ff[31:0];
         OFS_RES_HI:   prdata_out = res_ff[63:32];
         default:      pslverr_out = psel_in && penable_in;
      endcase
      if (!rd_acc) begin
         prdata_out = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         len_ff      <= LEN_RST;
         opt_ff      <= OPT_RST;
         op_cfg_ff   <= TES_OP_MAX_F32;
         src_ff      <= ADDR_RST;
         dst_ff      <= ADDR_RST;
         irq_stat_ff <= '0;
         irq_en_ff   <= '0;
      end else begin
         len_ff      <= nxt_len;
         opt_ff      <= nxt_opt;
         op_cfg_ff   <= nxt_op_cfg;
         src_ff      <= nxt_src;
         dst_ff      <= nxt_dst;
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff   <= nxt_irq_en;
      end
   end

   assign irq_out = |(irq_stat_ff & irq_en_ff);
endmodule : tes_search

// File: test/tes_search_asserts.sv
// Purpose: Port assertions for the table extremum search block.
// Assumes: Zero-wait APB slave and a held request on the word memory port.
// Notes:   Attached to every tes_search instance by the bind at the foot.
`timescale 1ns/1ps
module tes_search_asserts
   import tes_pkg::*;
(
   input wire logic              core_clk_in,   // Clock.
   input wire logic              nrst_in,       // Reset, active low.
   input wire logic              psel_in,       // APB select.
   input wire logic              penable_in,    // APB enable.
   input wire logic              pwrite_in,     // APB write.
   input wire logic [7:0]        paddr_in,      // APB address.
   input wire logic [31:0]       pwdata_in,     // APB write data.
   input wire logic [31:0]       prdata_out,    // APB read data.
   input wire logic              pready_out,    // APB ready.
   input wire logic              pslverr_out,   // APB error.
   input wire logic              mem_req_out,   // Memory request.
   input wire logic              mem_we_out,    // Memory write.
   input wire logic [ADDR_W-1:0] mem_addr_out,  // Memory address.
   input wire logic [WORD_W-1:0] mem_wdata_out, // Memory write data.
   input wire logic [WORD_W-1:0] mem_rdata_in,  // Memory read data.
   input wire logic              mem_ack_in,    // Memory acknowledge.
   input wire logic              irq_out        // Interrupt.
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);
   // ==========================================================
   // Memory port
   sequence s_rd_ack;
      mem_req_out && !mem_we_out && mem_ack_in;
   endsequence
   sequence s_wr_ack;
      mem_req_out && mem_we_out && mem_ack_in;
   endsequence
   property p_req_hold;
      mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
         && $stable(mem_we_out) && $stable(mem_wdata_out);
   endproperty
   property p_rd_step;
      s_rd_ack ##1 (mem_req_out && !mem_we_out) |-> mem_addr_out == $past(mem_addr_out) + 1'b1;
   endproperty
   property p_wr_step;
      s_wr_ack ##1 (mem_req_out && mem_we_out) |-> mem_addr_out == $past(mem_addr_out) + 1'b1;
   endproperty
   property p_we_req;
      mem_we_out |-> mem_req_out;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("memory request changed before ack");
   a_rd_step: assert property (p_rd_step) else $error("table read skipped a word");
   a_wr_step: assert property (p_wr_step) else $error("result write skipped a word");
   a_we_req: assert property (p_we_req) else $error("write strobe without request");
   // ==========================================================
   // Register bus and interrupt
   property p_pready;
      pready_out;
   endproperty
   property p_idle_rd;
      !(psel_in && penable_in && !pwrite_in) |-> prdata_out == 32'h0;
   endproperty
   property p_slverr;
      psel_in && penable_in |-> pslverr_out == (paddr_in > OFS_RES_HI || paddr_in[1:0] != 2'h0);
   endproperty
   property p_irq_mask;
      psel_in && penable_in && pwrite_in && paddr_in == OFS_IRQ_EN && pwdata_in[1:0] == 2'h0
         |=> !irq_out;
   endproperty
   a_pready: assert property (p_pready) else $error("ready low");
   a_idle_rd: assert property (p_idle_rd) else $error("read data outside a read");
   a_slverr: assert property (p_slverr) else $error("slave error mismatch");
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
endmodule : tes_search_asserts

bind tes_search tes_search_asserts tes_search_asserts_inst (.core_clk_in, .nrst_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
   .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_rdata_in, .mem_ack_in,
   .irq_out);

// File: test/tes_mem_model.sv
// Purpose: Word memory answering the search block's request port.
// Assumes: One acknowledge pulse per word, after a bench-set wait.
// Notes:   Read data is scrambled between acknowledges so stale words never pass.
`timescale 1ns/1ps
module tes_mem_model (
   input  wire logic        clk_in,    // Clock.
   input  wire logic        req_in,    // Request.
   input  wire logic        we_in,     // Write.
   input  wire logic [19:0] addr_in,   // Word address.
   input  wire logic [15:0] wdata_in,  // Write data.
   input  wire logic [3:0]  dly_in,    // Wait cycles before each acknowledge.
   output logic      [15:0] rdata_out, // Read data.
   output logic             ack_out    // Acknowledge pulse.
);
   logic [15:0] mem [0:255];
   logic [3:0]  wait_cnt = 4'h0;
   initial ack_out = 1'b0;
   initial rdata_out = 16'h0;
   always @(posedge clk_in) begin
      rdata_out <= ~rdata_out;
      if (ack_out || !req_in) begin
         ack_out <= 1'b0;
         wait_cnt <= 4'h0;
         if (ack_out && req_in && we_in) mem[addr_in[7:0]] <= wdata_in;
      end else if (wait_cnt < dly_in) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         ack_out <= 1'b1;
         rdata_out <= mem[addr_in[7:0]];
      end
   end
endmodule : tes_mem_model

// File: test/tb_table_extremum_search.sv
// Purpose: Self-checking bench for the table extremum search block.
// Assumes: Tables are preloaded straight into the memory model's array.
// Notes:   Results are read over APB and from the destination words.
`timescale 1ns/1ps
module tb_table_extremum_search;
   import tes_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, mreq, mwe, mack, irq;
   logic [19:0] maddr;
   logic [15:0] mwdata, mrdata;
   logic [3:0]  mdly = 4'h3;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cyc = 0;
   always #5 clk = ~clk;
   tes_search tes_search_inst (.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .mem_req_out(mreq),
      .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwdata),
      .mem_rdata_in(mrdata), .mem_ack_in(mack), .irq_out(irq));
   tes_mem_model tes_mem_model_inst (.clk_in(clk), .req_in(mreq), .we_in(mwe), .addr_in(maddr),
      .wdata_in(mwdata), .dly_in(mdly), .rdata_out(mrdata), .ack_out(mack));
   // ==========================================================
   // Tasks
   task tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task mchk(input logic [7:0] a, input logic [15:0] e);
      chk({16'h0, tes_mem_model_inst.mem[a]}, {16'h0, e});
   endtask : mchk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk
   task put(input logic [7:0] a, input logic [31:0] v);
      tes_mem_model_inst.mem[a] = v[15:0];
      tes_mem_model_inst.mem[a + 8'h1] = v[31:16];
   endtask : put
   // Starts one search and waits for busy to drop; m masks unchecked status bits.
   task run(input logic [1:0] op, input logic [15:0] opt, w, input logic [7:0] src,
            input logic [31:0] lo, hi, input logic [3:0] st, m);
      apb(1'b1, OFS_LEN, {16'h0, w});
      apb(1'b1, OFS_OPT, {16'h0, opt});
      apb(1'b1, OFS_OP, {30'h0, op});
      apb(1'b1, OFS_SRC, {24'h0, src});
      apb(1'b1, OFS_DST, 32'h60);
      apb(1'b1, OFS_START, 32'h1);
      rd = 32'h1;
      for (int i = 0; i < 200 && rd[0] !== 1'b0; i++) apb(1'b0, OFS_STATUS, 32'h0);
      chk({28'h0, rd[3:0] & (m | 4'h1)}, {28'h0, st & (m | 4'h1)});
      rchk(OFS_RES_LO, lo);
      rchk(OFS_RES_HI, hi);
   endtask : run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      put(8'h10, 32'h3F800000);
      put(8'h12, 32'h40000000);
      put(8'h14, 32'h40000000);
      put(8'h20, 32'h0);
      put(8'h22, 32'hBFF00000);
      put(8'h24, 32'h0);
      put(8'h26, 32'hC0000000);
      put(8'h30, 32'hFFFFFFFF);
      put(8'h32, 32'h00000001);
      put(8'h34, 32'h00000005);
      put(8'h36, 32'h0);
      put(8'h38, 32'hBF800000);
      put(8'h3A, 32'h0);
      put(8'h40, 32'h3F800000);
      put(8'h42, 32'hBF800000);
      put(8'h44, 32'h3F800000);
      put(8'h46, 32'h7FC00000);
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rchk(OFS_STATUS, 32'h0);
      rchk(OFS_INDEX, 32'h0);
      rchk(OFS_IRQ_STAT, 32'h0);
      rchk(8'h40, 32'h0);
      run(2'h0, 16'h4000, 16'h3, 8'h10, 32'h40000000, 32'h0, 4'h0, 4'hF);
      rchk(OFS_INDEX, 32'h12);
      run(2'h1, 16'h0, 16'h2, 8'h20, 32'h0, 32'hBFF00000, 4'h8, 4'hF);
      mchk(8'h63, 16'hBFF0);
      rchk(OFS_INDEX, 32'h12);
      run(2'h2, 16'h0, 16'h2, 8'h30, 32'h1, 32'h0, 4'h0, 4'hF);
      run(2'h2, 16'hC000, 16'h2, 8'h30, 32'hFFFFFFFF, 32'h0, 4'h8, 4'hF);
      rchk(OFS_INDEX, 32'h30);
      run(2'h2, 16'h8000, 16'h2, 8'h34, 32'h0, 32'h0, 4'h4, 4'hF);
      run(2'h0, 16'h0, 16'h2, 8'h38, 32'h0, 32'h0, 4'h4, 4'hF);
      run(2'h3, 16'h0, 16'h2, 8'h40, 32'hBF800000, 32'h0, 4'h0, 4'h2);
      mchk(8'h61, 16'hBF80);
      run(2'h0, 16'h0, 16'h2, 8'h44, 32'hBF800000, 32'h0, 4'h2, 4'h2);
      apb(1'b1, OFS_IRQ_CLR, 32'h3);
      run(2'h0, 16'h4000, 16'h0, 8'h10, 32'hBF800000, 32'h0, 4'h2, 4'h2);
      rchk(OFS_INDEX, 32'h30);
      mchk(8'h61, 16'hBF80);
      rchk(OFS_IRQ_STAT, 32'h3);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_IRQ_EN, 32'h3);
      #1 chk({31'h0, irq}, 32'h1);
      apb(1'b1, OFS_IRQ_EN, 32'h0);
      #1 chk({31'h0, irq}, 32'h0);
      apb(1'b1, OFS_IRQ_CLR, 32'h3);
      rchk(OFS_IRQ_STAT, 32'h0);
      mdly <= 4'h0;
      run(2'h2, 16'h0, 16'h2, 8'h30, 32'h1, 32'h0, 4'h0, 4'hF);
      tally_and_finish();
   end
endmodule : tb_table_extremum_search
